// >>> rtl/loop_clk_ctrl.sv
// loop programming, base clock select protection and lock change events
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module loop_clk_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lock_detect,
    input wire logic acq_done,
    input wire logic xtal_lost,
    input wire logic stop_mode,
    input wire logic break_state,
    output logic loop_enable,
    output logic [3:0] vco_mult_n,
    output logic [3:0] vco_range,
    output logic vco_track_mode,
    output logic xtal_clock_en,
    output logic base_clock_en,
    output logic base_src_vco,
    output logic clkgen_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // zero code and one code both give a divide by one
    function automatic logic [3:0] mult_of(input logic [3:0] code);
        mult_of = (code == loop_clk_pkg::zero_code) ? loop_clk_pkg::one_code : code;
    endfunction

    loop_clk_pkg::loop_ctl_t ctl;
    loop_clk_pkg::bw_ctl_t bw;
    logic [3:0] freq_mult_sel;
    logic [3:0] vco_range_sel;
    logic break_clear_enable;
    logic loop_change_flag;
    logic lock_meta;
    logic lock_sync;
    logic lock_prev;
    logic acq_meta;
    logic acq_sync;
    logic setup_phase;
    logic wr_access;
    logic rd_access;
    logic addr_hit;
    logic ctl_read;
    logic lock_toggle;
    logic range_off;
    logic lock_bit;
    logic track_bit;
    logic flag_view;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // no wait states; read data is captured in the setup cycle so it comes from a flop
    assign pready = 1'b1;
    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & penable & ~pwrite;
    assign addr_hit = (paddr == loop_clk_pkg::loop_control_addr) |
                      (paddr == loop_clk_pkg::bandwidth_ctl_addr) |
                      (paddr == loop_clk_pkg::loop_program_addr) |
                      (paddr == loop_clk_pkg::break_flag_ctl_addr);
    assign pslverr = psel & penable & ~addr_hit;

    // a debugger read in break with clear enable low must leave the flag alone
    assign ctl_read = rd_access & (paddr == loop_clk_pkg::loop_control_addr) &
                      (~break_state | break_clear_enable);

    // ------------------------------------------------------------
    // lock and acquisition synchronisers
    // ------------------------------------------------------------
    // the analogue detector is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            lock_prev <= 1'b0;
            acq_meta <= 1'b0;
            acq_sync <= 1'b0;
        end else begin
            lock_meta <= lock_detect;
            lock_sync <= lock_meta;
            lock_prev <= lock_sync;
            acq_meta <= acq_done;
            acq_sync <= acq_meta;
        end
    end

    // edges are judged only between settled samples
    assign lock_toggle = lock_sync ^ lock_prev;
    assign range_off = (vco_range_sel == loop_clk_pkg::zero_code);
    assign lock_bit = bw.auto_bw & lock_sync;
    assign track_bit = bw.auto_bw ? acq_sync : bw.manual_track;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // select may be set without lock; power, range and stop mode guard it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl.loop_irq_enable <= 1'b0;
            ctl.loop_power_on <= loop_clk_pkg::loop_power_on_rst;
            ctl.base_clk_sel <= 1'b0;
        end else if (stop_mode) begin
            ctl.base_clk_sel <= 1'b0;
        end else begin
            if (wr_access && paddr == loop_clk_pkg::loop_control_addr) begin
                if (bw.auto_bw) begin
                    ctl.loop_irq_enable <= pwdata[loop_clk_pkg::ctl_irq_en_bit];
                end
                // power cannot drop while the vco drives the base clock
                if (!ctl.base_clk_sel) begin
                    ctl.loop_power_on <= pwdata[loop_clk_pkg::ctl_pwr_on_bit];
                end
                // set needs power already on, so turning power on and selecting the vco takes two writes
                if (ctl.loop_power_on && !range_off) begin
                    ctl.base_clk_sel <= pwdata[loop_clk_pkg::ctl_bcs_bit];
                end else if (!pwdata[loop_clk_pkg::ctl_bcs_bit]) begin
                    ctl.base_clk_sel <= 1'b0;
                end
            end
            if (range_off) begin
                ctl.base_clk_sel <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // lock change flag
    // ------------------------------------------------------------
    // set wins over a read clear in the same cycle; a cleared flag is set again only by a later lock edge in auto mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_change_flag <= 1'b0;
        end else if (bw.auto_bw && lock_toggle) begin
            loop_change_flag <= 1'b1;
        end else if (ctl_read) begin
            loop_change_flag <= 1'b0;
        end
    end

    assign flag_view = loop_change_flag & bw.auto_bw;

    // ------------------------------------------------------------
    // bandwidth control register
    // ------------------------------------------------------------
    // the manual tracking value is kept while auto mode overrides it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw.auto_bw <= 1'b0;
            bw.manual_track <= 1'b0;
            bw.xld <= 1'b0;
        end else begin
            if (wr_access && paddr == loop_clk_pkg::bandwidth_ctl_addr) begin
                bw.auto_bw <= pwdata[loop_clk_pkg::bw_auto_bit];
                if (!bw.auto_bw) begin
                    bw.manual_track <= pwdata[loop_clk_pkg::bw_track_bit];
                end
                bw.xld <= pwdata[loop_clk_pkg::bw_xld_bit];
            end else if (!xtal_lost) begin
                bw.xld <= 1'b0; // an active crystal clears the pending loss probe
            end
        end
    end

    // ------------------------------------------------------------
    // programming register and break flag control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_mult_sel <= loop_clk_pkg::freq_mult_sel_rst;
            vco_range_sel <= loop_clk_pkg::vco_range_sel_rst;
        end else if (wr_access && paddr == loop_clk_pkg::loop_program_addr &&
                     !ctl.loop_power_on) begin
            freq_mult_sel <= pwdata[loop_clk_pkg::prog_mult_lsb +: 4];
            vco_range_sel <= pwdata[loop_clk_pkg::prog_range_lsb +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            break_clear_enable <= 1'b0;
        end else if (wr_access && paddr == loop_clk_pkg::break_flag_ctl_addr) begin
            break_clear_enable <= pwdata[loop_clk_pkg::bfc_clear_en_bit];
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        unique case (paddr)
            loop_clk_pkg::loop_control_addr: begin
                next_rdata[loop_clk_pkg::ctl_irq_en_bit] = ctl.loop_irq_enable & bw.auto_bw;
                next_rdata[loop_clk_pkg::ctl_flag_bit] = flag_view;
                next_rdata[loop_clk_pkg::ctl_pwr_on_bit] = ctl.loop_power_on;
                next_rdata[loop_clk_pkg::ctl_bcs_bit] = ctl.base_clk_sel;
                next_rdata[3:0] = loop_clk_pkg::ctl_unused_val;
            end
            loop_clk_pkg::bandwidth_ctl_addr: begin
                next_rdata[loop_clk_pkg::bw_auto_bit] = bw.auto_bw;
                next_rdata[loop_clk_pkg::bw_lock_bit] = lock_bit;
                next_rdata[loop_clk_pkg::bw_track_bit] = track_bit;
                next_rdata[loop_clk_pkg::bw_xld_bit] = bw.xld & ctl.base_clk_sel;
            end
            loop_clk_pkg::loop_program_addr: begin
                next_rdata = {freq_mult_sel, vco_range_sel};
            end
            loop_clk_pkg::break_flag_ctl_addr: begin
                next_rdata[loop_clk_pkg::bfc_clear_en_bit] = break_clear_enable;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // sampled in the setup cycle, held through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= {24'h00_0000, next_rdata};
        end
    end

    // ------------------------------------------------------------
    // outputs to the analogue loop and clock tree
    // ------------------------------------------------------------
    // wait mode has no effect here: the generator keeps running
    assign loop_enable = ctl.loop_power_on & ~range_off & ~stop_mode;
    assign vco_mult_n = mult_of(freq_mult_sel);
    assign vco_range = vco_range_sel;
    assign vco_track_mode = track_bit;
    assign xtal_clock_en = ~stop_mode;
    assign base_clock_en = ~stop_mode;
    assign base_src_vco = ctl.base_clk_sel;
    assign clkgen_irq = flag_view & ctl.loop_irq_enable & ~stop_mode;

endmodule // loop_clk_ctrl

`default_nettype wire

// >>> rtl/loop_clk_pkg.sv
// constants, field layouts and types for the loop programming and lock event block
package loop_clk_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] loop_control_addr = 8'h00;
    localparam logic [7:0] bandwidth_ctl_addr = 8'h04;
    localparam logic [7:0] loop_program_addr = 8'h08;
    localparam logic [7:0] break_flag_ctl_addr = 8'h0c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ctl_irq_en_bit = 7;
    localparam int ctl_flag_bit = 6;
    localparam int ctl_pwr_on_bit = 5;
    localparam int ctl_bcs_bit = 4;
    localparam logic [3:0] ctl_unused_val = 4'hf;
    localparam int bw_auto_bit = 7;
    localparam int bw_lock_bit = 6;
    localparam int bw_track_bit = 5;
    localparam int bw_xld_bit = 4;
    localparam int prog_mult_lsb = 4;
    localparam int prog_range_lsb = 0;
    localparam int bfc_clear_en_bit = 7;

    // ------------------------------------------------------------
    // reset values and the zero and one codes
    // ------------------------------------------------------------
    localparam logic [3:0] freq_mult_sel_rst = 4'h6;
    localparam logic [3:0] vco_range_sel_rst = 4'h6;
    localparam logic loop_power_on_rst = 1'b1;
    localparam logic [3:0] zero_code = 4'h0;
    localparam logic [3:0] one_code = 4'h1;

    // control register state carried as one group
    typedef struct packed {
        logic loop_irq_enable;
        logic loop_power_on;
        logic base_clk_sel;
    } loop_ctl_t;

    // bandwidth register state
    typedef struct packed {
        logic auto_bw;
        logic manual_track;
        logic xld;
    } bw_ctl_t;

endpackage

// >>> testbench/loop_clk_ctrl_chk.sv
// assertions on the ports of the loop control block
`timescale 1ns/1ps
`default_nettype none
module loop_clk_ctrl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic stop_mode,
    input wire logic loop_enable,
    input wire logic [3:0] vco_mult_n,
    input wire logic [3:0] vco_range,
    input wire logic xtal_clock_en,
    input wire logic base_clock_en,
    input wire logic base_src_vco,
    input wire logic clkgen_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // program register write landing at this edge
    wire logic prog_wr = psel && penable && pwrite && paddr == loop_clk_pkg::loop_program_addr;
    property p_mult_nonzero; vco_mult_n != 4'h0; endproperty
    property p_mult_locked; prog_wr && loop_enable |=> $stable(vco_mult_n); endproperty
    property p_range_locked; prog_wr && loop_enable |=> $stable(vco_range); endproperty
    property p_range_off; vco_range == 4'h0 |-> !loop_enable && !base_src_vco; endproperty
    property p_stop_low; stop_mode |-> !xtal_clock_en && !base_clock_en && !clkgen_irq; endproperty
    property p_stop_bcs; stop_mode |=> !base_src_vco; endproperty
    property p_bcs_power; $rose(base_src_vco) |-> $past(loop_enable); endproperty
    property p_run_clk; !stop_mode |-> xtal_clock_en && base_clock_en; endproperty
    a_mult_nonzero: assert property (p_mult_nonzero) else $error("multiplier zero");
    a_mult_locked: assert property (p_mult_locked) else $error("multiplier changed");
    a_range_locked: assert property (p_range_locked) else $error("range changed");
    a_range_off: assert property (p_range_off) else $error("range zero not off");
    a_stop_low: assert property (p_stop_low) else $error("outputs active in stop");
    a_stop_bcs: assert property (p_stop_bcs) else $error("select kept in stop");
    a_bcs_power: assert property (p_bcs_power) else $error("select set while off");
    a_run_clk: assert property (p_run_clk) else $error("clocks off outside stop");
endmodule // loop_clk_ctrl_chk
bind loop_clk_ctrl loop_clk_ctrl_chk i_loop_clk_ctrl_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .stop_mode(stop_mode),
    .loop_enable(loop_enable), .vco_mult_n(vco_mult_n), .vco_range(vco_range),
    .xtal_clock_en(xtal_clock_en), .base_clock_en(base_clock_en),
    .base_src_vco(base_src_vco), .clkgen_irq(clkgen_irq));
`default_nettype wire

// >>> testbench/loop_clk_ctrl_tb_top.sv
// self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
module loop_clk_ctrl_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic stop_mode = 1'b0;
    logic break_state = 1'b0;
    logic upset = 1'b1;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, lock_detect, acq_done, loop_enable, vco_track_mode;
    logic xtal_clock_en, base_clock_en, base_src_vco, clkgen_irq;
    logic [3:0] vco_mult_n, vco_range;
    int failures = 0;
    int total_checks = 0;
    localparam logic [7:0] ctl = loop_clk_pkg::loop_control_addr;
    localparam logic [7:0] bw = loop_clk_pkg::bandwidth_ctl_addr;
    localparam logic [7:0] prog = loop_clk_pkg::loop_program_addr;
    localparam logic [7:0] bfc = loop_clk_pkg::break_flag_ctl_addr;
    always #5 pclk = ~pclk;
    // crystal loss input tied inactive: loss detection is outside these tests
    loop_clk_ctrl i_loop_clk_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lock_detect(lock_detect), .acq_done(acq_done),
        .xtal_lost(1'b0), .stop_mode(stop_mode), .break_state(break_state),
        .loop_enable(loop_enable), .vco_mult_n(vco_mult_n), .vco_range(vco_range),
        .vco_track_mode(vco_track_mode), .xtal_clock_en(xtal_clock_en),
        .base_clock_en(base_clock_en), .base_src_vco(base_src_vco), .clkgen_irq(clkgen_irq));
    loop_model i_loop_model (.pclk(pclk), .loop_enable(loop_enable), .upset(upset),
        .lock_detect(lock_detect), .acq_done(acq_done));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; the request stays put until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // extra edge so outputs driven by the write have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, {24'h0, e});
    endtask
    task automatic wait_irq;
        for (int n = 0; n < 60 && clkgen_irq !== 1'b1; n++) @(posedge pclk);
        chk({31'h0, clkgen_irq}, 32'h1);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: the tests need well under a tenth of this span
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(ctl, 8'h2f);
        rd(prog, 8'h66);
        rd(bw, 8'h00);
        wr(prog, 8'h00);
        rd(prog, 8'h66);
        wr(ctl, 8'h00);
        wr(ctl, 8'h10);
        rd(ctl, 8'h0f);
        for (int i = 0; i < 16; i++) begin
            wr(prog, {i[3:0], 4'h6});
            chk({28'h0, vco_mult_n}, (i == 0) ? 32'h1 : 32'(i));
        end
        wr(prog, 8'h60);
        chk({28'h0, vco_range}, 32'h0);
        wr(ctl, 8'h20);
        chk({31'h0, loop_enable}, 32'h0);
        wr(ctl, 8'h30);
        rd(ctl, 8'h2f);
        wr(ctl, 8'h00);
        wr(prog, 8'h66);
        wr(ctl, 8'h20);
        $display("test programming done");
        wr(bw, 8'h80);
        wr(ctl, 8'ha0);
        upset <= 1'b0;
        wait_irq();
        rd(bw, 8'he0);
        chk({31'h0, vco_track_mode}, 32'h1);
        rd(ctl, 8'hef);
        rd(ctl, 8'haf);
        wr(ctl, 8'h20);
        upset <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({31'h0, clkgen_irq}, 32'h0);
        rd(ctl, 8'h6f);
        $display("test lock events done");
        break_state <= 1'b1;
        upset <= 1'b0;
        repeat (16) @(posedge pclk);
        rd(ctl, 8'h6f);
        rd(ctl, 8'h6f);
        break_state <= 1'b0;
        rd(ctl, 8'h6f);
        rd(ctl, 8'h2f);
        wr(bfc, 8'h80);
        break_state <= 1'b1;
        upset <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(ctl, 8'h6f);
        break_state <= 1'b0;
        rd(ctl, 8'h2f);
        $display("test break done");
        rd(bw, 8'h80);
        chk({31'h0, vco_track_mode}, 32'h0);
        wr(ctl, 8'h30);
        chk({31'h0, base_src_vco}, 32'h1);
        // deselect before stop: power stays on while the vco still drove the base clock
        wr(ctl, 8'h00);
        rd(ctl, 8'h2f);
        chk({31'h0, loop_enable}, 32'h1);
        wr(ctl, 8'h30);
        chk({31'h0, base_src_vco}, 32'h1);
        stop_mode <= 1'b1;
        @(posedge pclk);
        chk({29'h0, xtal_clock_en, base_clock_en, clkgen_irq}, 32'h0);
        @(posedge pclk);
        stop_mode <= 1'b0;
        rd(ctl, 8'h2f);
        wr(ctl, 8'ha0);
        upset <= 1'b0;
        wait_irq();
        wr(bw, 8'h00);
        chk({31'h0, clkgen_irq}, 32'h0);
        apb(1'b0, ctl, 32'h0);
        chk({31'h0, rdat[6]}, 32'h0);
        apb(1'b1, 8'h10, 32'hff);
        apb(1'b0, 8'h10, 32'h0);
        chk(rdat, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test stop and modes done");
        wrap_up();
    end
endmodule // loop_clk_ctrl_tb_top
`default_nettype wire

// >>> testbench/loop_model.sv
// behavioural analogue loop giving acquisition and lock levels
`timescale 1ns/1ps
`default_nettype none
module loop_model (
    input wire logic pclk,
    input wire logic loop_enable,
    input wire logic upset,
    output logic lock_detect,
    output logic acq_done
);
    int cnt = 0;
    // levels move by non-blocking update on the rising edge, so the block sees them one edge later
    always @(posedge pclk) begin
        cnt <= (!loop_enable || upset) ? 0 : ((cnt < 8) ? cnt + 1 : cnt);
    end
    assign acq_done = cnt >= 4;
    assign lock_detect = cnt >= 8;
endmodule // loop_model
`default_nettype wire
